/* test_usb_global_event_flags.sv */
`timescale 1ns/10ps
module test_usb_global_event_flags;
  // short idle count keeps the suspend scenarios brief
  localparam int unsigned IDLE_CYC = 50;
  localparam logic [7:0]  FA       = usbg_pkg::FLAGS_ADDR;
  localparam logic [7:0]  EA       = usbg_pkg::ENABLES_ADDR;
  logic                 clk_sys         = 1'b0;
  logic                 nrst            = 1'b0;
  logic                 upstream_resume = 1'b0;
  logic                 reg_wr          = 1'b0;
  logic                 reg_rd          = 1'b0;
  logic                 sof_cmd         = 1'b0;
  logic [7:0]           reg_addr        = 8'h00;
  logic [7:0]           reg_wdata       = 8'h00;
  logic [7:0]           reg_rdata;
  logic [7:0]           en;
  logic                 usb_dp;
  logic                 usb_dm;
  logic                 sof_received;
  logic                 usb_irq;
  logic                 bus_suspended;
  usbg_pkg::usbg_line_t line_cmd        = usbg_pkg::LINE_J;
  int                   errors          = 0;
  int                   cmp_count       = 0;
  int                   cyc             = 0;
  int                   seed_dummy;

  // ==========================================================
  // clock, instances, watchdog
  always #2.5 clk_sys = ~clk_sys;

  usbg_event_flags #(.SUSPEND_IDLE_CYCLES(IDLE_CYC)) usbg_event_flags_inst (
    .clk_sys(clk_sys), .nrst(nrst), .usb_dp_in(usb_dp), .usb_dm_in(usb_dm),
    .sof_received(sof_received), .upstream_resume(upstream_resume), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .usb_irq(usb_irq), .bus_suspended(bus_suspended));

  usbg_host_model usbg_host_model_inst (
    .clk_sys(clk_sys), .line_cmd(line_cmd), .sof_cmd(sof_cmd),
    .usb_dp(usb_dp), .usb_dm(usb_dm), .sof_received(sof_received));

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      $display("MISMATCH %0t watchdog expired", $time);
      final_report();
    end
  end

  // ==========================================================
  // bus tasks and compares
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk8(reg_rdata & mask, exp, "register read");
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic drive_line(input usbg_pkg::usbg_line_t st, input int n);
    @(posedge clk_sys);
    line_cmd <= st;
    idle(n);
  endtask

  function automatic logic exp_irq(input logic [7:0] f, input logic [7:0] e);
    return |(f & e & usbg_pkg::IMPL_MASK);
  endfunction

  task automatic final_report();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    seed_dummy = $urandom(73);
    idle(11);
    @(posedge clk_sys);
    nrst <= 1'b1;
    chk_reg(FA, 8'hFF, usbg_pkg::FLAGS_RESET);
    chk_reg(EA, 8'hFF, usbg_pkg::ENABLES_RESET);
    chk_reg(8'hBC, 8'hFF, 8'h00);
    idle(30);
    chk1(bus_suspended, 1'b0, "early suspend");
    idle(30);
    chk_reg(FA, 8'h01, 8'h01);
    wr(EA, 8'h01);
    chk1(usb_irq, 1'b1, "suspend irq on");
    wr(EA, 8'h00);
    chk1(usb_irq, 1'b0, "suspend irq off");
    wr(FA, 8'h39);
    chk_reg(FA, 8'hC7, 8'h01);
    wr(FA, 8'h38);
    chk_reg(FA, 8'h01, 8'h00);
    // own resume must leave suspend quietly
    @(posedge clk_sys);
    upstream_resume <= 1'b1;
    drive_line(usbg_pkg::LINE_K, 10);
    chk1(bus_suspended, 1'b0, "own resume");
    chk_reg(FA, 8'h20, 8'h00);
    @(posedge clk_sys);
    upstream_resume <= 1'b0;
    drive_line(usbg_pkg::LINE_J, IDLE_CYC + 15);
    chk1(bus_suspended, 1'b1, "suspend again");
    wr(FA, 8'h00);
    drive_line(usbg_pkg::LINE_K, 10);
    chk1(bus_suspended, 1'b0, "host wake");
    chk_reg(FA, 8'h20, 8'h20);
    wr(EA, 8'h20);
    chk1(usb_irq, 1'b1, "wake irq on");
    wr(EA, 8'h00);
    chk1(usb_irq, 1'b0, "wake irq off");
    idle(20);
    chk_reg(FA, 8'h20, 8'h20);
    wr(FA, 8'h19);
    chk_reg(FA, 8'h20, 8'h00);
    // line held K: no idle count, so flag state is fully known
    wr(FA, 8'h00);
    @(posedge clk_sys);
    sof_cmd <= 1'b1;
    @(posedge clk_sys);
    sof_cmd <= 1'b0;
    drive_line(usbg_pkg::LINE_SE0, usbg_pkg::BUS_RESET_MIN_CYC + 20);
    drive_line(usbg_pkg::LINE_K, 10);
    chk_reg(FA, 8'hFF, 8'h18);
    wr(EA, 8'h10);
    chk1(usb_irq, 1'b1, "reset-end irq");
    repeat (16)
    begin
      en = 8'($urandom) & usbg_pkg::IMPL_MASK;
      wr(EA, en);
      chk1(usb_irq, exp_irq(8'h18, en), "random irq");
      chk_reg(EA, 8'hFF, en);
    end
    wr(EA, 8'h08);
    chk1(usb_irq, 1'b1, "frame irq");
    wr(FA, 8'h31);
    chk_reg(FA, 8'hFF, 8'h10);
    chk1(usb_irq, 1'b0, "frame irq cleared");
    wr(8'hBC, 8'h00);
    chk_reg(FA, 8'hFF, 8'h10);
    // model delays the pulse one cycle, so it meets the clear below
    @(posedge clk_sys);
    sof_cmd <= 1'b1;
    @(posedge clk_sys);
    sof_cmd   <= 1'b0;
    reg_wr    <= 1'b1;
    reg_addr  <= FA;
    reg_wdata <= 8'h00;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
    chk_reg(FA, 8'hFF, 8'h08);
    chk1(usb_irq, 1'b1, "set beats clear");
    // second reset in mid-run with flags and enables changed
    @(posedge clk_sys);
    nrst <= 1'b0;
    idle(3);
    @(posedge clk_sys);
    nrst <= 1'b1;
    chk_reg(FA, 8'hFF, usbg_pkg::FLAGS_RESET);
    chk_reg(EA, 8'hFF, usbg_pkg::ENABLES_RESET);
    chk1(usb_irq, 1'b0, "irq after reset");
    final_report();
  end
endmodule

/* usbg_event_flags.sv */
`timescale 1ns/10ps
// How it works
// - wake-up flag sets on non-idle line while suspended, never on own resume
// - wake-up flag with its enable set raises the interrupt request
// - suspend flag sets after the bus idles in J for 3 ms
// - suspend flag with its enable raises interrupt; flag stays until cleared
// - reserved bits 7-6 and 2-1 read zero; software writes them zero
// - flag register resets to all zeros
// - enable bit 5 gates the wake-up interrupt
// - enable bit 4 gates the end-of-reset interrupt
// - end-of-reset enable is one after reset, others zero
// - enable bit 3 gates the start-of-frame interrupt
// - enable bit 0 gates the suspend interrupt
// - start-of-frame flag sets on each received start-of-frame packet
module usbg_event_flags
#(
  parameter int unsigned SUSPEND_IDLE_CYCLES = usbg_pkg::SUSPEND_IDLE_CYC
)
(
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  input  wire logic                         usb_dp_in,
  input  wire logic                         usb_dm_in,
  input  wire logic                         sof_received,
  input  wire logic                         upstream_resume,
  input  wire logic [usbg_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [usbg_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [usbg_pkg::DATA_W-1:0]  reg_rdata,
  output logic                              usb_irq,
  output logic                              bus_suspended
);

  // ==========================================================
  // constants and declarations
  localparam int unsigned IDLE_LAST_I = SUSPEND_IDLE_CYCLES - 1;
  localparam logic [usbg_pkg::IDLE_CNT_W-1:0] IDLE_LAST = IDLE_LAST_I[usbg_pkg::IDLE_CNT_W-1:0];
  localparam int unsigned SE0_MIN_I = usbg_pkg::BUS_RESET_MIN_CYC;
  localparam logic [usbg_pkg::SE0_CNT_W-1:0] SE0_MIN = SE0_MIN_I[usbg_pkg::SE0_CNT_W-1:0];

  usbg_pkg::usbg_line_t                 line_state;
  usbg_pkg::usbg_state_t                state_reg;
  usbg_pkg::usbg_state_t                state_next;
  logic [usbg_pkg::IDLE_CNT_W-1:0]      idle_cnt_reg;
  logic [usbg_pkg::SE0_CNT_W-1:0]       se0_cnt_reg;
  logic [usbg_pkg::DATA_W-1:0]          flags_reg;
  logic [usbg_pkg::DATA_W-1:0]          flags_next;
  logic [usbg_pkg::DATA_W-1:0]          enables_reg;
  logic [usbg_pkg::DATA_W-1:0]          set_mask;
  logic [usbg_pkg::DATA_W-1:0]          clr_mask;
  logic [usbg_pkg::DATA_W-1:0]          rdata_next;
  logic                                 line_j;
  logic                                 line_se0;
  logic                                 wake_evt;
  logic                                 suspend_evt;
  logic                                 reset_end_evt;
  logic                                 wr_flags;
  logic                                 wr_enables;
  logic                                 rd_flags;
  logic                                 rd_enables;
  logic [usbg_pkg::IDLE_CNT_W-1:0]      j_run_reg;

  function automatic logic usbg_hit(input logic [usbg_pkg::ADDR_W-1:0] addr,
                                    input logic [usbg_pkg::ADDR_W-1:0] target);
    return addr == target;
  endfunction

  // ==========================================================
  // line sampling
  usbg_line_sync u_line_sync
  (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .dp_pin     (usb_dp_in),
    .dm_pin     (usb_dm_in),
    .line_state (line_state)
  );

  assign line_j   = (line_state == usbg_pkg::LINE_J);
  assign line_se0 = (line_state == usbg_pkg::LINE_SE0);

  // ==========================================================
  // suspend / wake-up tracking
  always_comb
  begin
    state_next  = state_reg;
    wake_evt    = 1'b0;
    suspend_evt = 1'b0;
    unique case (state_reg)
      usbg_pkg::ST_ACTIVE:
      begin
        if (line_j && (idle_cnt_reg == IDLE_LAST))
        begin
          suspend_evt = 1'b1;
          state_next  = usbg_pkg::ST_SUSPENDED;
        end
      end
      usbg_pkg::ST_SUSPENDED:
      begin
        // our own resume drives K too; it wakes the link but is not host activity
        if (upstream_resume)
          state_next = usbg_pkg::ST_ACTIVE;
        else if (!line_j)
        begin
          wake_evt   = 1'b1;
          state_next = usbg_pkg::ST_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      state_reg <= usbg_pkg::ST_ACTIVE;
    else
      state_reg <= state_next;
  end

  // idle counter restarts on any non-J state and after each suspend
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      idle_cnt_reg <= '0;
    else if (!line_j || suspend_evt || (state_reg != usbg_pkg::ST_ACTIVE))
      idle_cnt_reg <= '0;
    else
      idle_cnt_reg <= idle_cnt_reg + 1'b1;
  end

  assign bus_suspended = (state_reg == usbg_pkg::ST_SUSPENDED);

  // plain run length of J, saturating; only the suspend timing check reads it
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      j_run_reg <= '0;
    else if (!line_j)
      j_run_reg <= '0;
    else if (j_run_reg != IDLE_LAST)
      j_run_reg <= j_run_reg + 1'b1;
  end

  // ==========================================================
  // bus reset end detection
  // saturating count; a short SE0 (end of packet) never reaches the minimum
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      se0_cnt_reg <= '0;
    else if (!line_se0)
      se0_cnt_reg <= '0;
    else if (se0_cnt_reg != SE0_MIN)
      se0_cnt_reg <= se0_cnt_reg + 1'b1;
  end

  assign reset_end_evt = !line_se0 && (se0_cnt_reg == SE0_MIN);

  // ==========================================================
  // register access
  assign wr_flags   = reg_wr && usbg_hit(reg_addr, usbg_pkg::FLAGS_ADDR);
  assign wr_enables = reg_wr && usbg_hit(reg_addr, usbg_pkg::ENABLES_ADDR);
  assign rd_flags   = reg_rd && usbg_hit(reg_addr, usbg_pkg::FLAGS_ADDR);
  assign rd_enables = reg_rd && usbg_hit(reg_addr, usbg_pkg::ENABLES_ADDR);

  always_comb
  begin
    set_mask = '0;
    set_mask[usbg_pkg::BIT_WAKEUP]      = wake_evt;
    set_mask[usbg_pkg::BIT_RESET_END]   = reset_end_evt;
    set_mask[usbg_pkg::BIT_FRAME_START] = sof_received;
    set_mask[usbg_pkg::BIT_SUSPEND]     = suspend_evt;
  end

  // writing zero clears a flag, writing one leaves it
  assign clr_mask   = wr_flags ? (~reg_wdata & usbg_pkg::IMPL_MASK) : '0;
  // set wins over a clear in the same cycle, so no event is lost
  assign flags_next = (flags_reg & ~clr_mask) | set_mask;

  // ==========================================================
  // flag and enable storage
  genvar gi;
  generate
    for (gi = 0; gi < usbg_pkg::DATA_W; gi++)
    begin : g_bits
      if (usbg_pkg::IMPL_MASK[gi])
      begin : g_impl
        always_ff @(posedge clk_sys)
        begin
          if (!nrst)
            flags_reg[gi] <= usbg_pkg::FLAGS_RESET[gi];
          else
            flags_reg[gi] <= flags_next[gi];
        end

        always_ff @(posedge clk_sys)
        begin
          if (!nrst)
            enables_reg[gi] <= usbg_pkg::ENABLES_RESET[gi];
          else if (wr_enables)
            enables_reg[gi] <= reg_wdata[gi];
        end
      end
      else
      begin : g_rsvd
        // no storage: reserved bits read zero whatever is written
        assign flags_reg[gi]   = 1'b0;
        assign enables_reg[gi] = 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // read data and interrupt
  always_comb
  begin
    rdata_next = usbg_pkg::RDATA_IDLE;
    if (rd_flags)
      rdata_next = flags_reg;
    else if (rd_enables)
      rdata_next = enables_reg;
  end

  // unmapped reads and idle cycles return zero
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      reg_rdata <= usbg_pkg::RDATA_IDLE;
    else
      reg_rdata <= rdata_next;
  end

  assign usb_irq = |(flags_reg & enables_reg);

  // ==========================================================
  // checks
  wakeup_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_reg == usbg_pkg::ST_SUSPENDED) && !line_j && !upstream_resume
    |=> flags_reg[usbg_pkg::BIT_WAKEUP] && (state_reg == usbg_pkg::ST_ACTIVE))
    else $error("wake-up flag not set on line activity");

  own_resume_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_reg == usbg_pkg::ST_SUSPENDED) && upstream_resume && !flags_reg[usbg_pkg::BIT_WAKEUP]
    |=> !flags_reg[usbg_pkg::BIT_WAKEUP])
    else $error("own resume set the wake-up flag");

  wakeup_irq_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    flags_reg[usbg_pkg::BIT_WAKEUP] |-> (usb_irq == (enables_reg[usbg_pkg::BIT_WAKEUP] ||
      |(flags_reg & enables_reg & ~(8'h01 << usbg_pkg::BIT_WAKEUP)))))
    else $error("wake-up interrupt gating wrong");

  wakeup_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    flags_reg[usbg_pkg::BIT_WAKEUP] && !(wr_flags && !reg_wdata[usbg_pkg::BIT_WAKEUP])
    |=> flags_reg[usbg_pkg::BIT_WAKEUP])
    else $error("wake-up flag dropped without software clear");

  suspend_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    suspend_evt |-> (idle_cnt_reg == IDLE_LAST) && line_j ##1
      flags_reg[usbg_pkg::BIT_SUSPEND] && bus_suspended)
    else $error("suspend not flagged after idle time");

  suspend_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    flags_reg[usbg_pkg::BIT_SUSPEND] && !wr_flags |=> flags_reg[usbg_pkg::BIT_SUSPEND])
    else $error("suspend flag dropped without software clear");

  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    reg_rd |=> (reg_rdata[7:6] == 2'h0) && (reg_rdata[2:1] == 2'h0))
    else $error("reserved bits read nonzero");

  reset_value_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !$past(nrst) |-> (flags_reg == usbg_pkg::FLAGS_RESET) && (reg_rdata == usbg_pkg::RDATA_IDLE))
    else $error("flag register not cleared by reset");

  enable_reset_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !$past(nrst) |-> (enables_reg == usbg_pkg::ENABLES_RESET))
    else $error("enable register reset value wrong");

  enable_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_enables |=> (enables_reg == ($past(reg_wdata) & usbg_pkg::IMPL_MASK)))
    else $error("enable write not stored");

  irq_or_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !usb_irq |-> ((flags_reg & enables_reg) == 8'h00))
    else $error("interrupt low while an enabled flag is set");

  frame_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sof_received |=> flags_reg[usbg_pkg::BIT_FRAME_START])
    else $error("start-of-frame flag not set");

  reset_end_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    line_se0 && (se0_cnt_reg == SE0_MIN) ##1 !line_se0 |=> flags_reg[usbg_pkg::BIT_RESET_END])
    else $error("end of bus reset not flagged");

  read_data_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd_flags |=> (reg_rdata == $past(flags_reg)))
    else $error("flag read data wrong");

  read_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !reg_rd |=> (reg_rdata == usbg_pkg::RDATA_IDLE))
    else $error("read data not zero outside a read");

  enable_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd_enables |=> (reg_rdata == $past(enables_reg)))
    else $error("enable read data wrong");

  reserved_store_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ((flags_reg | enables_reg) & ~usbg_pkg::IMPL_MASK) == 8'h00)
    else $error("reserved bit holds a one");

  reset_end_irq_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    flags_reg[usbg_pkg::BIT_RESET_END] && enables_reg[usbg_pkg::BIT_RESET_END] |-> usb_irq)
    else $error("end-of-reset interrupt missing");

  frame_irq_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    flags_reg[usbg_pkg::BIT_FRAME_START] && enables_reg[usbg_pkg::BIT_FRAME_START] |-> usb_irq)
    else $error("start-of-frame interrupt missing");

  suspend_irq_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    flags_reg[usbg_pkg::BIT_SUSPEND] && enables_reg[usbg_pkg::BIT_SUSPEND] |-> usb_irq)
    else $error("suspend interrupt missing");

  flag_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_flags |=> ((flags_reg & ~$past(set_mask) & ~$past(reg_wdata)) == 8'h00))
    else $error("flag not cleared by writing zero");

  set_wins_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (set_mask != 8'h00) |=> ((flags_reg & $past(set_mask)) == $past(set_mask)))
    else $error("flag event lost");

  suspend_time_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(flags_reg[usbg_pkg::BIT_SUSPEND]) |-> $past(line_j) && ($past(j_run_reg) == IDLE_LAST))
    else $error("suspend flagged before the idle time");

  wake_only_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(flags_reg[usbg_pkg::BIT_WAKEUP]) |-> $past(bus_suspended) && !$past(upstream_resume))
    else $error("wake-up flag set outside suspend");

  frame_only_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(flags_reg[usbg_pkg::BIT_FRAME_START]) |-> $past(sof_received))
    else $error("start-of-frame flag set without a packet");

  reset_end_time_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(flags_reg[usbg_pkg::BIT_RESET_END]) |-> ($past(se0_cnt_reg) == SE0_MIN) && !$past(line_se0))
    else $error("end of reset flagged after a short SE0");

endmodule

/* usbg_host_model.sv */
`timescale 1ns/10ps
// ==========================================================
// far-side line driver
module usbg_host_model
(
  input  wire logic                 clk_sys,
  input  wire usbg_pkg::usbg_line_t line_cmd,
  input  wire logic                 sof_cmd,
  output logic                      usb_dp,
  output logic                      usb_dm,
  output logic                      sof_received
);
  // the line is always driven here, so no released level has to be modelled
  assign usb_dp = (line_cmd == usbg_pkg::LINE_J) || (line_cmd == usbg_pkg::LINE_SE1);
  assign usb_dm = (line_cmd == usbg_pkg::LINE_K) || (line_cmd == usbg_pkg::LINE_SE1);
  // packet decoder lives upstream; its pulse leaves one cycle after the request
  always_ff @(posedge clk_sys)
    sof_received <= sof_cmd;
endmodule

/* usbg_line_sync.sv */
`timescale 1ns/10ps
module usbg_line_sync
(
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire logic                dp_pin,
  input  wire logic                dm_pin,
  output usbg_pkg::usbg_line_t     line_state
);

  // ==========================================================
  // three-stage synchroniser per pin
  logic [2:0] dp_sync_reg;
  logic [2:0] dm_sync_reg;
  usbg_pkg::usbg_line_t line_reg;

  function automatic usbg_pkg::usbg_line_t usbg_decode(input logic dp, input logic dm);
    usbg_pkg::usbg_line_t res;
    res = usbg_pkg::LINE_SE0;
    if (dp && !dm)
      res = usbg_pkg::LINE_J;
    else if (!dp && dm)
      res = usbg_pkg::LINE_K;
    else if (dp && dm)
      res = usbg_pkg::LINE_SE1;
    return res;
  endfunction

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      dp_sync_reg <= 3'h7; // idle J has D+ high, so no false SE0 follows reset
      dm_sync_reg <= 3'h0;
    end
    else
    begin
      dp_sync_reg <= {dp_sync_reg[1:0], dp_pin};
      dm_sync_reg <= {dm_sync_reg[1:0], dm_pin};
    end
  end

  // stage 0 feeds stage 1 only; a change is taken once stages 1 and 2 agree
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      line_reg <= usbg_pkg::LINE_J;
    else if ((dp_sync_reg[1] == dp_sync_reg[2]) && (dm_sync_reg[1] == dm_sync_reg[2]))
      line_reg <= usbg_decode(dp_sync_reg[2], dm_sync_reg[2]);
  end

  assign line_state = line_reg;

endmodule

/* usbg_pkg.sv */
package usbg_pkg;

  // ==========================================================
  // register map
  localparam int unsigned ADDR_W            = 8;
  localparam int unsigned DATA_W            = 8;
  localparam logic [7:0]  FLAGS_ADDR        = 8'hBD;
  localparam logic [7:0]  ENABLES_ADDR      = 8'hBE;

  // ==========================================================
  // field positions, shared by flags and enables
  localparam int unsigned BIT_SUSPEND       = 0;
  localparam int unsigned BIT_FRAME_START   = 3;
  localparam int unsigned BIT_RESET_END     = 4;
  localparam int unsigned BIT_WAKEUP        = 5;
  localparam logic [7:0]  IMPL_MASK         = 8'h39;

  // ==========================================================
  // reset values
  localparam logic [7:0]  FLAGS_RESET       = 8'h00;
  localparam logic [7:0]  ENABLES_RESET     = 8'h10;
  localparam logic [7:0]  RDATA_IDLE        = 8'h00;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_PS     = 5000;
  localparam int unsigned SUSPEND_IDLE_US   = 3000;
  localparam int unsigned SUSPEND_IDLE_CYC  = (SUSPEND_IDLE_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned IDLE_CNT_W        = 20;
  localparam int unsigned BUS_RESET_MIN_NS  = 2700;
  localparam int unsigned BUS_RESET_MIN_CYC = (BUS_RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SE0_CNT_W         = 10;

  // ==========================================================
  // types
  typedef enum logic [1:0] {LINE_SE0, LINE_J, LINE_K, LINE_SE1} usbg_line_t;
  typedef enum logic {ST_ACTIVE, ST_SUSPENDED} usbg_state_t;

endpackage
